/* src/dlc_params.svh */
// Purpose: constants for the converter latch controller
// Assumes: 10 MHz system clock
// Notes:   byte addresses on a 32-bit classic Wishbone slave
`ifndef DLC_PARAMS_SVH
`define DLC_PARAMS_SVH

`define DLC_CLK_PERIOD_NS   100
`define DLC_WR_MIN_NS       900
`define DLC_WR_CYC \
   ((`DLC_WR_MIN_NS + `DLC_CLK_PERIOD_NS - 1) / `DLC_CLK_PERIOD_NS)
`define DLC_HOLD_MIN_NS     50
`define DLC_HOLD_CYC \
   ((`DLC_HOLD_MIN_NS + `DLC_CLK_PERIOD_NS - 1) / `DLC_CLK_PERIOD_NS)

`define DLC_ADR_DATA        8'h00
`define DLC_ADR_CTRL        8'h04
`define DLC_ADR_STAT        8'h08

`define DLC_CTRL_MODE_LSB   0
`define DLC_CTRL_ILE_BIT    2
`define DLC_CTRL_COPY_TO_CONVERTER_N_BIT   3
`define DLC_CTRL_GO_BIT     4

`define DLC_STAT_BUSY_BIT   0
`define DLC_STAT_DONE_BIT   1

`define DLC_DATA_RST        8'h00
`define DLC_MODE_RST        2'h0

`endif

/* src/dlc_pkg.sv */
// Purpose: types for the converter latch controller
// Assumes: nothing
// Notes:   modes select how the two device latches are driven
package dlc_pkg;
   typedef enum logic [1:0] {
      DLC_MODE_SINGLE = 2'h0,
      DLC_MODE_DOUBLE = 2'h1,
      DLC_MODE_FLOW   = 2'h2,
      DLC_MODE_XONLY  = 2'h3
   } dlc_mode_t;

   typedef struct packed {
      logic       input_write_strobe_n;
      logic       transfer_write_strobe_n;
      logic       copy_to_converter_n;
      logic       chip_select_n;
      logic       input_latch_enable;
   } dlc_ctl_t;
endpackage

/* src/dlc_ctrl.sv */
// Purpose: drives the pins of an 8-bit double-buffered multiplying
//          converter from a Wishbone register set
// Assumes: device pins are plain outputs; 10 MHz SYS_CLK
// Notes:   strobes last a whole number of clock cycles
//
// Behaviour
// RULE1 - single-buffered: one latch held transparent, the other captures
// RULE2 - controller uses the input register as the holding latch
// RULE3 - select, strobe two, transfer low, enable high: strobe one updates
// RULE4 - all controls low and enable high make both latches flow through
// RULE5 - each write strobe is held low at least 900 ns
// RULE6 - device captures code on the rising edge of a selected strobe
// RULE7 - short bus cycles are stretched until the strobe width is met; here ack comes after one wait state
// RULE8 - data stays valid on the pins while a strobe is low
// RULE9 - code is straight binary 0..255, currents code/256 and complement
// RULE10 - each set bit steers current to the true output, else complement
// RULE11 - enable low freezes the input register regardless of strobe one
// RULE12 - converter register loads on transfer with strobe two
// RULE13 - shared transfer changes only converters whose input was written
// RULE14 - both device registers are level-sensitive latches
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "dlc_params.svh"
`default_nettype none

module dlc_ctrl
   import dlc_pkg::*;
(
   // system
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output var  logic [31:0] WB_DAT_O,
   output var  logic        WB_ACK_O,
   // device pins
   output var  logic [7:0]  DAC_DATA,
   output var  dlc_ctl_t    DAC_CTL
);

   typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_HOLD} dlc_state_t;

   localparam logic [3:0] WR_CYC   = 4'(`DLC_WR_CYC);
   localparam logic [3:0] HOLD_CYC = 4'(`DLC_HOLD_CYC);
   // one extra leading cycle: latch-mode pins settle before any strobe
   localparam logic [3:0] RUN_CYC  = 4'(`DLC_WR_CYC + 1);

   logic [7:0]  data_reg;
   dlc_mode_t   mode_reg;
   logic        ile_reg;
   logic        copy_to_converter_n_reg;
   logic        done_reg;
   logic        go;
   logic        strobe_one;
   dlc_state_t  state_reg;
   logic [3:0]  cnt_reg;
   logic        wb_req;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ==========================================================
   // bus slave: one wait state, ack pulses one cycle
   assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign go = wb_req && WB_WE_I && WB_SEL_I[0]
               && hit(WB_ADR_I, `DLC_ADR_CTRL)
               && WB_DAT_I[`DLC_CTRL_GO_BIT] && (state_reg == ST_IDLE);

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= wb_req;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         WB_DAT_O <= 32'h0;
      end else if (wb_req && !WB_WE_I) begin
         if (hit(WB_ADR_I, `DLC_ADR_DATA)) begin
            WB_DAT_O <= {24'h0, data_reg};
         end else if (hit(WB_ADR_I, `DLC_ADR_CTRL)) begin
            WB_DAT_O <= {28'h0, copy_to_converter_n_reg, ile_reg, mode_reg};
         end else if (hit(WB_ADR_I, `DLC_ADR_STAT)) begin
            WB_DAT_O <= {30'h0, done_reg, state_reg != ST_IDLE};
         end else begin
            WB_DAT_O <= 32'h0;
         end
      end
   end

   // data is locked while a strobe sequence runs
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         data_reg <= `DLC_DATA_RST;
      end else if (wb_req && WB_WE_I && WB_SEL_I[0]
                   && hit(WB_ADR_I, `DLC_ADR_DATA)
                   && state_reg == ST_IDLE) begin
         data_reg <= WB_DAT_I[7:0]; // RULE8
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mode_reg <= dlc_mode_t'(`DLC_MODE_RST);
         ile_reg  <= 1'b1;
         copy_to_converter_n_reg <= 1'b0;
      end else if (wb_req && WB_WE_I && WB_SEL_I[0]
                   && hit(WB_ADR_I, `DLC_ADR_CTRL)
                   && state_reg == ST_IDLE) begin
         mode_reg <= dlc_mode_t'(WB_DAT_I[`DLC_CTRL_MODE_LSB +: 2]);
         ile_reg  <= WB_DAT_I[`DLC_CTRL_ILE_BIT];
         copy_to_converter_n_reg <= WB_DAT_I[`DLC_CTRL_COPY_TO_CONVERTER_N_BIT];
      end
   end

   // ==========================================================
   // strobe sequencer
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (go && mode_reg != DLC_MODE_FLOW) begin
                  state_reg <= ST_STROBE;
                  cnt_reg   <= RUN_CYC; // RULE5 RULE7
               end
            end
            ST_STROBE: begin
               if (cnt_reg == 4'h1) begin
                  state_reg <= ST_HOLD;
                  cnt_reg   <= HOLD_CYC; // RULE8
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_HOLD: begin
               if (cnt_reg == 4'h1) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         done_reg <= 1'b0;
      end else if (state_reg == ST_HOLD && cnt_reg == 4'h1) begin
         done_reg <= 1'b1;
      end else if (go) begin
         done_reg <= 1'b0;
      end
   end

   // a mode change and a strobe edge never reach the pins together,
   // so a closing converter latch cannot glimpse the new code
   assign strobe_one = (state_reg == ST_STROBE)
                       && (cnt_reg != RUN_CYC); // RULE5 RULE8

   // ==========================================================
   // device pins
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DAC_DATA <= `DLC_DATA_RST;
      end else begin
         DAC_DATA <= data_reg; // RULE9 RULE10
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DAC_CTL <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      end else begin
         DAC_CTL.input_latch_enable <= ile_reg; // RULE11
         DAC_CTL.chip_select_n      <= 1'b0;
         case (mode_reg)
            DLC_MODE_SINGLE: begin
               // converter latch open, input latch holds
               DAC_CTL.input_write_strobe_n    <= !strobe_one; // RULE2
               DAC_CTL.transfer_write_strobe_n <= 1'b0;
               DAC_CTL.copy_to_converter_n     <= 1'b0;
            end
            DLC_MODE_DOUBLE: begin
               // load input latch only; optional shared transfer
               DAC_CTL.input_write_strobe_n    <= !strobe_one; // RULE6 RULE13
               DAC_CTL.transfer_write_strobe_n <= !(strobe_one && copy_to_converter_n_reg);
               DAC_CTL.copy_to_converter_n     <= !(strobe_one && copy_to_converter_n_reg);
            end
            DLC_MODE_FLOW: begin
               DAC_CTL.input_write_strobe_n    <= 1'b0; // RULE4 RULE14
               DAC_CTL.transfer_write_strobe_n <= 1'b0;
               DAC_CTL.copy_to_converter_n     <= 1'b0;
            end
            DLC_MODE_XONLY: begin
               // transfer only: held code goes to converter
               DAC_CTL.input_write_strobe_n    <= 1'b1;
               DAC_CTL.transfer_write_strobe_n <= !strobe_one; // RULE12 RULE5
               DAC_CTL.copy_to_converter_n     <= !strobe_one;
            end
            default: begin
               DAC_CTL.input_write_strobe_n    <= 1'b1;
               DAC_CTL.transfer_write_strobe_n <= 1'b1;
               DAC_CTL.copy_to_converter_n     <= 1'b1;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* dv/dlc_ctrl_asserts.sv */
// Purpose: pin timing checks for the latch controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   flow mode (all strobes low) is exempt from input_latch_a only
`timescale 1ns/1ps
`default_nettype none
module dlc_ctrl_asserts
   import dlc_pkg::*;
(
   // system
   input wire logic       SYS_CLK,
   input wire logic       RESET_N,
   // device pins
   input wire logic [7:0] DAC_DATA,
   input wire dlc_ctl_t   DAC_CTL
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   logic s1;
   logic fl;
   assign s1 = DAC_CTL.input_write_strobe_n;
   assign fl = !s1 && !DAC_CTL.transfer_write_strobe_n
               && !DAC_CTL.copy_to_converter_n;
   sequence low_nine;
      !s1 [*8] ##1 !s1;
   endsequence
   strobe_width_a: assert property ($fell(s1) |-> low_nine)
      else $error("write strobe shorter than nine cycles");
   data_hold_a: assert property ($rose(s1) |->
      DAC_DATA == $past(DAC_DATA, 9) ##1 $stable(DAC_DATA))
      else $error("data moved around the latching edge");
   input_latch_a: assert property ($changed(DAC_DATA) && !fl |-> s1)
      else $error("data changed while input latch open");
   select_qual_a: assert property (!s1 |-> !DAC_CTL.chip_select_n)
      else $error("strobe low without chip select");
endmodule
bind dlc_ctrl dlc_ctrl_asserts chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .DAC_DATA(DAC_DATA), .DAC_CTL(DAC_CTL));
`default_nettype wire

/* dv/dlc_dev_model.sv */
// Purpose: behavioural model of the double-latched converter
// Assumes: level-sensitive latches, no clock
// Notes:   currents shown as the true and complement codes
`timescale 1ns/1ps
`default_nettype none
module dlc_dev_model
   import dlc_pkg::*;
(
   input wire logic [7:0]  d,
   input wire dlc_ctl_t    c,
   output var logic [7:0]  true_code,
   output var logic [7:0]  comp_code
);
   logic [7:0] in_reg;
   // input latch captures on a qualified strobe, frozen by enable low
   always_latch begin
      if (c.input_latch_enable && !c.chip_select_n && !c.input_write_strobe_n)
         in_reg <= d;
   end
   // converter latch, independent of chip select
   always_latch begin
      if (!c.transfer_write_strobe_n && !c.copy_to_converter_n)
         true_code <= in_reg;
   end
   assign comp_code = ~true_code;
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench for the latch controller
// Assumes: 10 MHz clock, classic Wishbone master
// Notes:   expected codes tracked in in_m and dac_m
`timescale 1ns/1ps
`default_nettype none
module tb
   import dlc_pkg::*;
;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack;
   logic [7:0]  adr = 8'h00, pins, code, comp, v;
   logic [31:0] wdat = 32'h0, rdat, q;
   dlc_ctl_t    ctl;
   int          errors = 0, check_count = 0, seed = 14214;
   int          in_m = 0, dac_m = 0;
   logic [7:0]  dq[$];
   dlc_ctrl uut (.SYS_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
      .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .DAC_DATA(pins),
      .DAC_CTL(ctl));
   dlc_dev_model dev (.d(pins), .c(ctl), .true_code(code), .comp_code(comp));
   initial forever #50 clk = ~clk;
   task automatic results;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
         if (n > 20) begin
            errors++;
            results;
         end
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // start a latch sequence and poll until it finishes
   task automatic go(input logic [7:0] c);
      int n;
      n = 0;
      wb(1'b1, 8'h04, c);
      do begin
         wb(1'b0, 8'h08, 8'h00);
         n++;
         if (n > 20) begin
            errors++;
            results;
         end
      end while (q[0] !== 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wb(1'b0, 8'h0c, 8'h00);
      chk(q, 0);
      chk(ctl, 32'h11);
      // the device's input latch powers up unknown: load a known code
      wb(1'b1, 8'h00, 8'h00);
      go(8'h14);
      chk(code, dac_m);
      repeat (6) dq.push_back(8'($random(seed)));
      while (dq.size() > 0) begin
         v = dq.pop_front();
         wb(1'b1, 8'h00, v);
         chk(pins, v);
         chk(code, dac_m);
         go(8'h14);
         dac_m = v;
         chk(code, dac_m);
         chk(comp, 255 - dac_m);
      end
      v = 8'($random(seed));
      wb(1'b1, 8'h00, v);
      go(8'h10);
      chk(code, dac_m);
      go(8'h15);
      in_m = v;
      chk(code, dac_m);
      go(8'h17);
      dac_m = in_m;
      chk(code, dac_m);
      wb(1'b1, 8'h00, ~v);
      go(8'h1d);
      chk(code, {24'h0, ~v});
      wb(1'b1, 8'h04, 8'h06);
      repeat (3) begin
         v = 8'($random(seed));
         wb(1'b1, 8'h00, v);
         chk(code, v);
      end
      repeat (12) @(posedge clk);
      results;
   end
endmodule
`default_nettype wire
